// >>> hw/udbt_pkg.sv
`default_nettype none
package udbt_pkg;
	////////////////////////////////////////////////////////////////
	localparam int CLK_NS = 50;
	localparam int TW = 4;
	localparam int DW = 16;
	localparam int MODES = 3;
	localparam int CYC_NS [MODES] = '{114, 75, 55};
	localparam int T2CYC_NS [MODES] = '{235, 156, 117};
	localparam int DVS_NS [MODES] = '{70, 48, 34};
	localparam int FS_NS [MODES] = '{230, 200, 170};
	localparam int RFS_NS [MODES] = '{75, 60, 50};
	localparam int LI_NS = 150;
	localparam int MLI_NS = 20;
	localparam int ZAH_NS = 20;
	localparam int SS_NS = 50;
	localparam logic [DW-1:0] CRC_INIT = 16'h4ABA;
	localparam logic [DW-1:0] CRC_POLY = 16'h1021;
	localparam logic [1:0] MODE_TOP = 2'h2;
	localparam logic [TW-1:0] T_ZERO = 4'h0;
	localparam logic [TW-1:0] T_ONE = 4'h1;
	localparam logic [TW-1:0] T_SAT = 4'hF;

	////////////////////////////////////////////////////////////////
	// Least times round up, longest times round down
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cyc

	function automatic int floor_cyc(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : floor_cyc

	function automatic int mode_idx(input logic [1:0] m);
		return (m > MODE_TOP) ? int'(MODE_TOP) : int'(m);
	endfunction : mode_idx

	localparam int SS_CYC = ceil_cyc(SS_NS);
	localparam int LI_CYC = floor_cyc(LI_NS);
	localparam int MLI_CYC = ceil_cyc(MLI_NS);
	localparam int ZAH_CYC = ceil_cyc(ZAH_NS);
	localparam logic [TW-1:0] ZAH_LOAD = TW'(ZAH_CYC > MLI_CYC ? ZAH_CYC : MLI_CYC);

	// Edge spacing also leaves data setup before each edge
	function automatic logic [TW-1:0] space_cyc(input logic [1:0] m);
		int i;
		int a;
		int b;
		int c;
		i = mode_idx(m);
		a = ceil_cyc(CYC_NS[i]);
		b = (ceil_cyc(T2CYC_NS[i]) + 1) / 2;
		c = ceil_cyc(DVS_NS[i]) + 1;
		if (b > a) a = b;
		if (c > a) a = c;
		return TW'(a);
	endfunction : space_cyc

	function automatic logic [TW:0] t2_cyc(input logic [1:0] m);
		return (TW+1)'(ceil_cyc(T2CYC_NS[mode_idx(m)]));
	endfunction : t2_cyc

	function automatic logic [1:0] dvs_cyc(input logic [1:0] m);
		return 2'(ceil_cyc(DVS_NS[mode_idx(m)]));
	endfunction : dvs_cyc

	function automatic logic [TW-1:0] fs_cyc(input logic [1:0] m);
		return TW'(floor_cyc(FS_NS[mode_idx(m)]));
	endfunction : fs_cyc

	typedef enum logic [2:0] {
		S_IDLE, S_ACK, S_TURN, S_START, S_RUN, S_SS, S_STOPW, S_REL
	} udbt_state_t;
endpackage : udbt_pkg
`default_nettype wire

// >>> hw/udbt_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface udbt_tmr_if;
	logic load;
	logic [udbt_pkg::TW-1:0] value;
	logic expired;
	modport ctrl (output load, output value, input expired);
	modport tmr (input load, input value, output expired);
endinterface : udbt_tmr_if
`default_nettype wire

// >>> hw/udbt_sync.sv
`timescale 1ns/10ps
`default_nettype none
module udbt_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} udbt_sync_t;

	udbt_sync_t r;
	udbt_sync_t next_r;

	// First stage feeds only the second
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= {INIT, INIT};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;
endmodule : udbt_sync
`default_nettype wire

// >>> hw/udbt_timer.sv
`timescale 1ns/10ps
`default_nettype none
module udbt_timer (
	input wire logic clk,
	input wire logic reset,
	udbt_tmr_if.tmr t
);
	import udbt_pkg::*;

	typedef struct packed {
		logic [TW-1:0] cnt;
	} udbt_timer_t;

	udbt_timer_t r;
	udbt_timer_t next_r;

	// Expires exactly value cycles after the load cycle; a value of zero acts as one
	always_comb begin
		next_r = r;
		if (t.load) begin
			next_r.cnt = (t.value == T_ZERO) ? T_ZERO : TW'(t.value - T_ONE);
		end else if (r.cnt != T_ZERO) begin
			next_r.cnt = TW'(r.cnt - T_ONE);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign t.expired = (r.cnt == T_ZERO);
endmodule : udbt_timer
`default_nettype wire

// >>> hw/udbt_burst.sv
`timescale 1ns/10ps
`default_nettype none
module udbt_burst (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] mode,
	input wire logic [udbt_pkg::DW-1:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	output logic busy,
	output logic done,
	output logic crc_error,
	output logic dmarq,
	input wire logic dmack_n,
	input wire logic stop,
	input wire logic hdmardy_n,
	output logic dstrobe,
	output logic dstrobe_oe,
	output logic [udbt_pkg::DW-1:0] dd_out,
	output logic dd_oe,
	input wire logic [udbt_pkg::DW-1:0] dd_in
);
	import udbt_pkg::*;

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		udbt_state_t st;
		logic dmarq;
		logic strobe;
		logic strobe_oe;
		logic dd_oe;
		logic [DW-1:0] dd;
		logic have;
		logic [1:0] age;
		logic last;
		logic hstop;
		logic [DW-1:0] crc;
		logic crc_error;
		logic done;
		logic [TW-1:0] since;
		logic [TW-1:0] gap;
	} udbt_regs_t;

	udbt_regs_t r;
	udbt_regs_t next_r;

	localparam int SYNC_W = DW + 3;
	localparam logic [SYNC_W-1:0] SYNC_INIT = {{DW{1'b0}}, 3'h7};
	localparam int LI_A = LI_CYC;

	logic [SYNC_W-1:0] pins_s;
	logic dmack_n_s;
	logic stop_s;
	logic hdmardy_n_s;
	logic [DW-1:0] dd_s;
	logic dmack_act;
	logic active;
	logic paused;
	logic age_ok;
	logic strobe_go;
	logic first_go;

	udbt_tmr_if tif ();

	////////////////////////////////////////////////////////////////
	udbt_sync #(
		.W(SYNC_W),
		.INIT(SYNC_INIT)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.d({dd_in, hdmardy_n, stop, dmack_n}),
		.q(pins_s)
	);

	udbt_timer u_timer (
		.clk(clk),
		.reset(reset),
		.t(tif)
	);

	assign dmack_n_s = pins_s[0];
	assign stop_s = pins_s[1];
	assign hdmardy_n_s = pins_s[2];
	assign dd_s = pins_s[SYNC_W-1:3];

	////////////////////////////////////////////////////////////////
	function automatic logic [DW-1:0] crc_step(input logic [DW-1:0] c, input logic [DW-1:0] d);
		logic [DW-1:0] x;
		logic fb;
		x = c;
		for (int i = 0; i < DW; i++) begin
			fb = x[DW-1] ^ d[i];
			x = {x[DW-2:0], 1'b0} ^ (fb ? CRC_POLY : {DW{1'b0}});
		end
		return x;
	endfunction : crc_step

	function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
		return (v == T_SAT) ? v : TW'(v + T_ONE);
	endfunction : sat_inc

	////////////////////////////////////////////////////////////////
	assign dmack_act = ~dmack_n_s;
	assign active = r.dmarq & dmack_act;
	assign paused = hdmardy_n_s;
	assign age_ok = (r.age >= 2'(dvs_cyc(mode) - 2'h1));
	assign tx_ready = ((r.st == S_START) || (r.st == S_RUN)) && !r.have && !r.last;
	// Ready withdrawn stops edges at once; sync latency bounds the overrun
	assign first_go = (r.st == S_START) && active && !stop_s && !paused && r.have && age_ok;
	assign strobe_go = first_go || ((r.st == S_RUN) && active && !stop_s && !paused && tif.expired
		&& r.have && age_ok);

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.since = sat_inc(r.since);
		next_r.age = (r.age == 2'h3) ? r.age : 2'(r.age + 2'h1);
		tif.load = 1'b0;
		tif.value = T_ZERO;
		if (tx_valid && tx_ready) begin
			next_r.dd = tx_data;
			next_r.have = 1'b1;
			next_r.age = 2'h0;
			next_r.last = tx_last;
		end
		if (strobe_go) begin
			next_r.strobe = ~r.strobe;
			next_r.have = 1'b0;
			next_r.crc = crc_step(r.crc, r.dd);
			next_r.since = T_ZERO;
			next_r.gap = sat_inc(r.since);
			tif.load = 1'b1;
			tif.value = space_cyc(mode);
			next_r.st = r.last ? S_SS : S_RUN;
		end
		case (r.st)
			S_IDLE: begin
				if (tx_valid) begin
					next_r.dmarq = 1'b1;
					next_r.crc = CRC_INIT;
					next_r.crc_error = 1'b0;
					// A word left over from a cut burst keeps its end mark
					next_r.last = r.have & r.last;
					next_r.hstop = 1'b0;
					next_r.st = S_ACK;
				end
			end
			S_ACK: begin
				// Wait as long as the host needs
				if (dmack_act) begin
					tif.load = 1'b1;
					tif.value = ZAH_LOAD;
					next_r.st = S_TURN;
				end
			end
			S_TURN: begin
				if (tif.expired) begin
					next_r.strobe = 1'b1;
					next_r.strobe_oe = 1'b1;
					next_r.dd_oe = 1'b1;
					next_r.since = T_SAT;
					next_r.gap = T_SAT;
					next_r.st = S_START;
				end
			end
			S_START: begin
				// Leaves only through the first edge, so spacing starts from it
				next_r.st = strobe_go ? next_r.st : r.st;
			end
			S_RUN: begin
				// Host stop ends the burst; a pause alone just holds
				if (active && stop_s) begin
					next_r.hstop = 1'b1;
					next_r.st = S_SS;
				end
			end
			S_SS: begin
				if (r.since >= TW'(SS_CYC - 1)) begin
					next_r.dmarq = 1'b0;
					if (r.hstop) begin
						next_r.dd_oe = 1'b0;
						next_r.strobe_oe = 1'b0;
						next_r.st = S_REL;
					end else begin
						next_r.st = S_STOPW;
					end
				end
			end
			S_STOPW: begin
				if (stop_s || !dmack_act) begin
					next_r.dd_oe = 1'b0;
					next_r.strobe_oe = 1'b0;
					next_r.st = S_REL;
				end
			end
			S_REL: begin
				// Data lines and acknowledge share the same sync depth
				if (!dmack_act) begin
					next_r.crc_error = (dd_s != r.crc);
					next_r.done = 1'b1;
					next_r.st = S_IDLE;
				end
			end
			default: begin
				next_r.st = r.st;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy = (r.st != S_IDLE);
	assign done = r.done;
	assign crc_error = r.crc_error;
	assign dmarq = r.dmarq;
	assign dstrobe = r.strobe;
	assign dstrobe_oe = r.strobe_oe;
	assign dd_out = r.dd;
	assign dd_oe = r.dd_oe;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	edge_space_a: assert property (strobe_go && (r.st == S_RUN) |-> r.since >= TW'(space_cyc(mode) - T_ONE))
		else $error("strobe edges too close");

	two_cycle_a: assert property (strobe_go |-> ((TW+1)'(r.gap) + (TW+1)'(r.since) + 5'h1) >= t2_cyc(mode))
		else $error("same-polarity strobe edges too close");

	first_strobe_a: assert property (first_go |=> $fell(dstrobe) && dstrobe_oe)
		else $error("first strobe negation missing");

	pause_one_a: assert property ($rose(paused) && active |-> ##1 $stable(dstrobe) ##1 $stable(dstrobe))
		else $error("strobe moved after ready withdrawn");

	ready_stop_a: assert property (active && paused |=> $stable(dstrobe))
		else $error("strobe edge while host not ready");

	term_gap_a: assert property ($fell(dmarq) |-> $stable(dstrobe) && $past(r.since) >= TW'(SS_CYC - 1))
		else $error("request dropped too soon after last edge");

	stop_answer_a: assert property (active && stop_s && (r.st == S_RUN) |-> ##[1:LI_A] !dmarq)
		else $error("host stop not answered in time");

	ack_wait_a: assert property ($rose(dstrobe_oe) |-> $past(dmack_act) && $past(dmack_act, 2))
		else $error("strobe driven before acknowledge settled");

	wait_rel_a: assert property ((r.st == S_REL) && dmack_act |=> (r.st == S_REL) && !dd_oe)
		else $error("left release wait without acknowledge drop");

	turnaround_a: assert property ($rose(dd_oe) |-> $past(dmack_act, 2) && $past(r.st) == S_TURN)
		else $error("data lines driven without turnaround");

	idle_quiet_a: assert property (!r.dmarq && !dmack_act |=> $stable(dstrobe))
		else $error("strobe moved outside a burst");

	ack_gate_a: assert property (!active && (r.st != S_TURN) |=> $stable(dstrobe))
		else $error("strobe moved before request and acknowledge");

	stop_gate_a: assert property (stop_s && (r.st != S_TURN) |=> $stable(dstrobe))
		else $error("strobe moved while host stop seen");

	start_hold_a: assert property ((r.st == S_START) && !first_go |=> $stable(dstrobe))
		else $error("strobe moved before first edge decided");

	crc_seed_a: assert property ((r.st == S_IDLE) && tx_valid |=> r.crc == CRC_INIT)
		else $error("checksum not seeded at burst start");

	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");

	release_pair_a: assert property ($fell(dd_oe) |-> $fell(dstrobe_oe))
		else $error("data and strobe released apart");

	idle_request_a: assert property ((r.st == S_IDLE) |-> !dmarq)
		else $error("request high while idle");
endmodule : udbt_burst
`default_nettype wire

// >>> test/udbt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module udbt_host_model (
	input wire logic clk,
	input wire logic dmarq,
	input wire logic dstrobe,
	input wire logic dstrobe_oe,
	input wire logic [udbt_pkg::DW-1:0] dd_out,
	input wire logic dd_oe,
	output logic dmack_n,
	output logic stop,
	output logic hdmardy_n,
	output logic [udbt_pkg::DW-1:0] dd_in
);
	import udbt_pkg::*;
	logic [DW-1:0] got [$];
	logic [DW-1:0] crc, hval, keep;
	logic hdrv, bad_crc, live;
	int pause_after, edges;
	realtime t_edge, t_prev, t_stop, t_rdy, min_any, min_same, fs_max, ss_min, rfs_max;
	////////////////////////////////////////////////////////////////
	function automatic logic [DW-1:0] crc_step(input logic [DW-1:0] c, input logic [DW-1:0] d);
		logic [DW-1:0] r;
		r = c;
		for (int i = 0; i < DW; i++) r = {r[DW-2:0], 1'b0} ^ ((r[DW-1] ^ d[i]) ? CRC_POLY : 16'h0000);
		return r;
	endfunction : crc_step

	task automatic clr();
		min_any = 1.0e6;
		min_same = 1.0e6;
		ss_min = 1.0e6;
		fs_max = 0.0;
		rfs_max = -1.0e6;
	endtask : clr
	////////////////////////////////////////////////////////////////
	// Released bus never shows its stale word
	assign dd_in = (dd_oe === 1'b1) ? dd_out : (hdrv ? hval : ~keep);
	always @(dd_out) if (dd_oe === 1'b1) keep = dd_out;
	assign live = dstrobe_oe === 1'b1 && dmack_n === 1'b0 && stop === 1'b0;

	always @(dstrobe) begin
		if (live && (edges > 0 || dstrobe === 1'b0)) begin
			if (edges == 0 && $realtime - t_stop > fs_max) fs_max = $realtime - t_stop;
			if (edges > 0 && $realtime - t_edge < min_any) min_any = $realtime - t_edge;
			if (edges > 1 && $realtime - t_prev < min_same) min_same = $realtime - t_prev;
			if (hdmardy_n === 1'b1) rfs_max = $realtime - t_rdy;
			t_prev = t_edge;
			t_edge = $realtime;
			got.push_back(dd_out);
			crc = crc_step(crc, dd_out);
			edges++;
		end
	end
	always @(negedge dmarq) if (edges > 0 && $realtime - t_edge < ss_min) ss_min = $realtime - t_edge;

	initial begin
		dmack_n = 1'b1;
		stop = 1'b1;
		hdmardy_n = 1'b1;
		hdrv = 1'b0;
		bad_crc = 1'b0;
		hval = 16'h0000;
		keep = 16'h0000;
		crc = CRC_INIT;
		pause_after = 0;
		edges = 0;
		clr();
		forever begin
			@(negedge clk iff dmarq === 1'b1);
			@(negedge clk);
			dmack_n = 1'b0;
			crc = CRC_INIT;
			edges = 0;
			#30;
			stop = 1'b0;
			hdmardy_n = 1'b0;
			t_stop = $realtime;
			while (dmarq === 1'b1 && !(pause_after > 0 && edges >= pause_after)) @(negedge clk);
			if (dmarq === 1'b1) begin
				hdmardy_n = 1'b1;
				t_rdy = $realtime;
				pause_after = 0;
				#200;
			end
			stop = 1'b1;
			// No protocol timeout here, the bench limit catches a hang
			wait (dstrobe_oe === 1'b0 && dd_oe === 1'b0);
			#25;
			hval = bad_crc ? ~crc : crc;
			hdrv = 1'b1;
			dmack_n = 1'b1;
			repeat (3) @(negedge clk);
			hdrv = 1'b0;
			hdmardy_n = 1'b1;
		end
	end
endmodule : udbt_host_model
`default_nettype wire

// >>> test/tb_udbt_burst.sv
`timescale 1ns/10ps
`default_nettype none
module tb_udbt_burst;
	import udbt_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [DW-1:0] tx_data = 16'h0000;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic tx_ready, busy, done, crc_error, dmarq, dmack_n, stop, hdmardy_n, dstrobe, dstrobe_oe, dd_oe;
	logic [DW-1:0] dd_out, dd_in;
	logic [DW-1:0] exp_q [$];
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int dn_cnt = 0;
	int seq = 0;
	////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;
	udbt_burst u_dut (.clk(clk), .reset(reset), .mode(mode), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .tx_ready(tx_ready), .busy(busy), .done(done), .crc_error(crc_error),
		.dmarq(dmarq), .dmack_n(dmack_n), .stop(stop), .hdmardy_n(hdmardy_n), .dstrobe(dstrobe),
		.dstrobe_oe(dstrobe_oe), .dd_out(dd_out), .dd_oe(dd_oe), .dd_in(dd_in));
	udbt_host_model u_host (.clk(clk), .dmarq(dmarq), .dstrobe(dstrobe), .dstrobe_oe(dstrobe_oe),
		.dd_out(dd_out), .dd_oe(dd_oe), .dmack_n(dmack_n), .stop(stop), .hdmardy_n(hdmardy_n), .dd_in(dd_in));
	always @(posedge clk) if (done === 1'b1) dn_cnt++;
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask : check

	// Ready is sampled a step after the falling edge, where it has settled
	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			tx_valid = 1'b1;
			tx_data = 16'h5A00 ^ DW'(seq * 787);
			tx_last = (i == n - 1);
			exp_q.push_back(tx_data);
			seq++;
			#1;
			while (tx_ready !== 1'b1) @(negedge clk) #1;
			@(posedge clk);
		end
		@(negedge clk);
		tx_valid = 1'b0;
		tx_last = 1'b0;
	endtask : send

	task automatic run(input logic [1:0] m, input int n, input int k);
		int goal;
		goal = dn_cnt + k;
		@(negedge clk);
		mode = m;
		u_host.clr();
		send(n);
		while (dn_cnt < goal) @(negedge clk);
	endtask : run

	task automatic cmp_words();
		check("word count", exp_q.size(), u_host.got.size());
		foreach (exp_q[i]) if (i < u_host.got.size()) check("word", exp_q[i], u_host.got[i]);
		check("idle after burst", 0, {busy, dstrobe_oe, dd_oe, dmarq});
		exp_q.delete();
		u_host.got.delete();
	endtask : cmp_words
	////////////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		check("reset outputs", 0, {dmarq, dstrobe_oe, dd_oe, busy, done, crc_error, tx_ready});
		check("reset data", 0, dd_out);
	endtask : t_reset_vals

	task automatic t_bad_crc();
		u_host.bad_crc = 1'b1;
		run(2'h2, 3, 1);
		check("crc flag set", 1, crc_error);
		u_host.bad_crc = 1'b0;
		cmp_words();
	endtask : t_bad_crc

	// Each mode has its own limits, and a good burst clears an old error
	task automatic t_modes();
		for (int m = 0; m < MODES; m++) begin
			run(2'(m), 5, 1);
			check("crc flag clear", 0, crc_error);
			check("edge spacing", 1, u_host.min_any >= CYC_NS[m]);
			check("same edge spacing", 1, u_host.min_same >= T2CYC_NS[m]);
			check("first strobe", 1, u_host.fs_max <= FS_NS[m] + 4 * CLK_NS);
			check("strobe to request", 1, u_host.ss_min >= SS_NS);
			cmp_words();
		end
	endtask : t_modes

	// Host pauses and stops, device resumes the rest in a second burst
	task automatic t_host_stop();
		u_host.pause_after = 3;
		run(2'h1, 8, 2);
		check("late strobe", 1, u_host.rfs_max <= RFS_NS[1] + 4 * CLK_NS);
		check("crc after stop", 0, crc_error);
		cmp_words();
	endtask : t_host_stop

	initial begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		t_reset_vals();
		t_bad_crc();
		t_modes();
		t_host_stop();
		end_of_test();
	end
endmodule : tb_udbt_burst
`default_nettype wire
